// file: lae_line_maint.sv
// Line maintenance: loss handling, zero runs, counter, flags and interrupt.
// Assumes pins from the analog front end are asynchronous and the other
// event inputs and transmit data come from logic on the same clock.
`timescale 1ns/1ps
module lae_line_maint #(
    parameter int SECOND_CYCLES = lae_pkg::SECOND_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic rx_mark_pin,
    input wire logic rx_level_low_pin,
    input wire logic rx_level_ok_pin,
    input wire logic driver_fail_pin,
    input wire logic pulse_sum_overflow,
    input wire logic tx_jitter_slip,
    input wire logic rx_jitter_slip,
    input wire logic bipolar_violation,
    input wire logic tx_data,
    output logic rx_data_out,
    output logic tx_data_out,
    output logic tx_bpv_insert,
    output logic [4:0] los_declare_code,
    output logic [4:0] los_clear_code,
    output logic [3:0] tx_match,
    output logic [3:0] rx_match,
    output logic rx_term_bypass,
    output logic int_n
);
    import lae_pkg::*;

    // Software registers.
    logic [7:0] rx_code_reg;
    logic [7:0] loss_level_reg;
    logic [7:0] loss_resp_reg;
    logic [7:0] maint2_reg;
    logic [7:0] term_reg;
    logic [7:0] line_ien_reg;
    logic [7:0] err_ien_reg;
    logic [7:0] edge_reg;
    logic [7:0] line_flags;
    logic [7:0] err_flags;
    logic [15:0] count_hold;

    // Line side state.
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic rx_mark_s;
    logic level_low_s;
    logic level_ok_s;
    logic driver_fail_state;
    logic signal_loss_state;
    logic driver_fail_prev;
    logic signal_loss_prev;
    logic inject_prev;
    logic snapshot_prev;
    logic [6:0] zero_run;
    logic [15:0] zero_count;
    logic [31:0] second_timer;
    logic second_tick;
    logic zero_event;
    logic [6:0] zero_limit;
    logic count_enable;
    logic [7:0] line_set;
    logic [7:0] err_set;
    logic [7:0] line_clr;
    logic [7:0] err_clr;
    logic [7:0] next_rdata;

    // A flag applies the write-one clear before it picks up its set.
    function automatic logic [7:0] next_flags(input logic [7:0] cur,
                                             input logic [7:0] set,
                                             input logic [7:0] clr);
        return set | (cur & ~clr);
    endfunction

    // Edge mode 0 sees a rise only, edge mode 1 sees any change.
    function automatic logic status_event(input logic prev,
                                          input logic cur,
                                          input logic any_change);
        return any_change ? (prev ^ cur) : (~prev & cur);
    endfunction

    // Decodes a three-bit impedance code into one-hot matching selects; bit 2 set gives none.
    function automatic logic [3:0] match_decode(input logic [2:0] code);
        return code[2] ? 4'h0 : 4'(4'h1 << code[1:0]);
    endfunction

    assign rx_mark_s = pin_s2[0];
    assign level_low_s = pin_s2[1];
    assign level_ok_s = pin_s2[2];
    assign driver_fail_state = pin_s2[3];

    // Two-flop synchronisers for the analog front end pins.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pin_s1 <= 4'h0;
            pin_s2 <= 4'h0;
        end else begin
            pin_s1 <= {driver_fail_pin, rx_level_ok_pin, rx_level_low_pin,
                       rx_mark_pin};
            pin_s2 <= pin_s1;
        end
    end

    // Loss of signal declare and clear.
    lae_loss_detect u_loss (
        .clk(clk),
        .rstn(rstn),
        .bit_mark(rx_mark_s),
        .level_low(level_low_s),
        .level_ok(level_ok_s),
        .criterion(loss_resp_reg[CRITERION_BIT]),
        .loss(signal_loss_state)
    );

    // Control register writes; only documented bits are kept.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rx_code_reg <= RST_ZERO;
            loss_level_reg <= RST_LOSS_LEVEL;
            loss_resp_reg <= RST_ZERO;
            maint2_reg <= RST_ZERO;
            term_reg <= RST_TERM;
            line_ien_reg <= RST_ZERO;
            err_ien_reg <= RST_ZERO;
            edge_reg <= RST_ZERO;
        end else if (wr) begin
            unique case (addr)
                ADDR_RX_CODE: rx_code_reg <= wdata & MASK_RX_CODE;
                ADDR_LOSS_LEVEL: loss_level_reg <= wdata & MASK_LOSS_LEVEL;
                ADDR_LOSS_RESP: loss_resp_reg <= wdata & MASK_LOSS_RESP;
                ADDR_MAINT2: maint2_reg <= wdata & MASK_MAINT2;
                ADDR_TERM: term_reg <= wdata & MASK_TERM;
                ADDR_LINE_IEN: line_ien_reg <= wdata & MASK_LINE;
                ADDR_ERR_IEN: err_ien_reg <= wdata & MASK_ERR;
                ADDR_EDGE: edge_reg <= wdata & MASK_LINE;
                default: ;
            endcase
        end
    end

    // One violation per rising edge of the inject bit.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            inject_prev <= 1'b0;
            tx_bpv_insert <= 1'b0;
        end else begin
            inject_prev <= maint2_reg[INJECT_BIT];
            tx_bpv_insert <= maint2_reg[INJECT_BIT] & ~inject_prev;
        end
    end

    // All-ones insertion while loss of signal stands.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rx_data_out <= 1'b0;
            tx_data_out <= 1'b0;
        end else begin
            rx_data_out <= rx_mark_s |
                (loss_resp_reg[RX_ONES_BIT] & signal_loss_state);
            tx_data_out <= tx_data |
                (loss_resp_reg[TX_ONES_BIT] & signal_loss_state);
        end
    end

    // Declare and clear level codes for the front end comparators.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            los_declare_code <= RST_LOSS_LEVEL[4:0];
            los_clear_code <= RST_LOSS_LEVEL[4:0] - HYST_CODES;
        end else begin
            los_declare_code <= loss_level_reg[4:0];
            if (loss_level_reg[4:0] >= HYST_CODES) begin
                los_clear_code <= loss_level_reg[4:0] - HYST_CODES;
            end else begin
                los_clear_code <= 5'h00;
            end
        end
    end

    // Impedance matching selects.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            tx_match <= match_decode(RST_TERM[TX_TERM_LSB +: 3]);
            rx_match <= match_decode(RST_TERM[RX_TERM_LSB +: 3]);
            rx_term_bypass <= RST_TERM[RX_TERM_LSB + 2];
        end else begin
            tx_match <= match_decode(term_reg[TX_TERM_LSB +: 3]);
            rx_match <= match_decode(term_reg[RX_TERM_LSB +: 3]);
            rx_term_bypass <= term_reg[RX_TERM_LSB + 2];
        end
    end

    // Zero run limit from criterion and receive line code.
    always_comb begin
        if (!rx_code_reg[RX_CODE_BIT]) begin
            zero_limit = EXZ_B8ZS;
        end else if (maint2_reg[ZRUN_CRIT_BIT]) begin
            zero_limit = EXZ_FCC_AMI;
        end else begin
            zero_limit = EXZ_ANSI_AMI;
        end
        zero_event = ~rx_mark_s & (zero_run == zero_limit);
        count_enable = maint2_reg[CNT_EN_LSB +: 2] == CNT_EN_CODE;
    end

    // Consecutive zero counter on received data, saturating.
    always_ff @(posedge clk) begin
        if (!rstn || rx_mark_s) begin
            zero_run <= 7'h00;
        end else if (zero_run != 7'h7F) begin
            zero_run <= zero_run + 7'h01;
        end
    end

    // Internal 16-bit excessive zero counter.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            zero_count <= 16'h0000;
        end else if (zero_event && count_enable) begin
            zero_count <= zero_count + 16'h0001;
        end
    end

    // One second report tick.
    always_ff @(posedge clk) begin
        if (!rstn || second_tick) begin
            second_timer <= 32'h00000000;
        end else begin
            second_timer <= second_timer + 32'h00000001;
        end
    end
    assign second_tick = second_timer == 32'(SECOND_CYCLES - 1);

    // Counter hold registers, manual or automatic.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            snapshot_prev <= 1'b0;
            count_hold <= 16'h0000;
        end else begin
            snapshot_prev <= maint2_reg[SNAPSHOT_BIT];
            if (maint2_reg[REPORT_MODE_BIT]) begin
                if (second_tick) begin
                    count_hold <= zero_count;
                end
            end else if (maint2_reg[SNAPSHOT_BIT] && !snapshot_prev) begin
                count_hold <= zero_count;
            end
        end
    end

    // Event sources and write-one clears for both flag registers.
    always_comb begin
        line_set = 8'h00;
        err_set = 8'h00;
        line_set[DF_BIT] = status_event(driver_fail_prev, driver_fail_state,
                                        edge_reg[DF_BIT]);
        line_set[LOS_BIT] = status_event(signal_loss_prev, signal_loss_state,
                                         edge_reg[LOS_BIT]);
        err_set[PSUM_BIT] = pulse_sum_overflow;
        err_set[TJA_BIT] = tx_jitter_slip;
        err_set[RJA_BIT] = rx_jitter_slip;
        err_set[EXZ_BIT] = zero_event;
        err_set[CV_BIT] = bipolar_violation;
        err_set[CNTOV_BIT] = zero_event & count_enable &
                             (zero_count == 16'hFFFF);
        line_clr = (wr && addr == ADDR_LINE_FLAGS) ? wdata & MASK_LINE : 8'h00;
        err_clr = (wr && addr == ADDR_ERR_FLAGS) ? wdata & MASK_ERR : 8'h00;
    end

    // Sticky flags; a set in the clearing cycle wins.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            driver_fail_prev <= 1'b0;
            signal_loss_prev <= 1'b0;
            line_flags <= 8'h00;
            err_flags <= 8'h00;
        end else begin
            driver_fail_prev <= driver_fail_state;
            signal_loss_prev <= signal_loss_state;
            line_flags <= next_flags(line_flags, line_set, line_clr);
            err_flags <= next_flags(err_flags, err_set, err_clr);
        end
    end

    // Interrupt pin, active low, from enabled flags.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            int_n <= 1'b1;
        end else begin
            int_n <= ~(|(line_flags & line_ien_reg) |
                       |(err_flags & err_ien_reg));
        end
    end

    // Read multiplexer; unmapped addresses read zero.
    always_comb begin
        next_rdata = 8'h00;
        unique case (addr)
            ADDR_RX_CODE: next_rdata = rx_code_reg;
            ADDR_LOSS_LEVEL: next_rdata = loss_level_reg;
            ADDR_LOSS_RESP: next_rdata = loss_resp_reg;
            ADDR_MAINT2: next_rdata = maint2_reg;
            ADDR_TERM: next_rdata = term_reg;
            ADDR_LINE_IEN: next_rdata = line_ien_reg;
            ADDR_ERR_IEN: next_rdata = err_ien_reg;
            ADDR_EDGE: next_rdata = edge_reg;
            ADDR_LINE_STATUS: begin
                next_rdata[DF_BIT] = driver_fail_state;
                next_rdata[LOS_BIT] = signal_loss_state;
            end
            ADDR_LINE_FLAGS: next_rdata = line_flags;
            ADDR_ERR_FLAGS: next_rdata = err_flags;
            ADDR_CNT_HIGH: next_rdata = count_hold[15:8];
            ADDR_CNT_LOW: next_rdata = count_hold[7:0];
            default: next_rdata = 8'h00;
        endcase
    end

    // Read data stands in the cycle after the strobe only.
    always_ff @(posedge clk) begin
        if (!rstn || !rd) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end
endmodule

// file: lae_pkg.sv
// Constants for the line alarm, error and interrupt control block.
// Assumes one 125 MHz clock in which every clock cycle is one bit interval.
package lae_pkg;

    // Register byte addresses on the plain 8-bit register port.
    localparam logic [7:0] ADDR_RX_CODE = 8'h28;
    localparam logic [7:0] ADDR_LOSS_LEVEL = 8'h29;
    localparam logic [7:0] ADDR_LOSS_RESP = 8'h2C;
    localparam logic [7:0] ADDR_MAINT2 = 8'h31;
    localparam logic [7:0] ADDR_TERM = 8'h32;
    localparam logic [7:0] ADDR_LINE_IEN = 8'h33;
    localparam logic [7:0] ADDR_ERR_IEN = 8'h34;
    localparam logic [7:0] ADDR_EDGE = 8'h35;
    localparam logic [7:0] ADDR_LINE_STATUS = 8'h36;
    localparam logic [7:0] ADDR_LINE_FLAGS = 8'h3A;
    localparam logic [7:0] ADDR_ERR_FLAGS = 8'h3B;
    localparam logic [7:0] ADDR_CNT_HIGH = 8'h3C;
    localparam logic [7:0] ADDR_CNT_LOW = 8'h3D;

    // Field positions.
    localparam int RX_CODE_BIT = 0;
    localparam int CRITERION_BIT = 4;
    localparam int RX_ONES_BIT = 3;
    localparam int TX_ONES_BIT = 2;
    localparam int INJECT_BIT = 6;
    localparam int ZRUN_CRIT_BIT = 4;
    localparam int CNT_EN_LSB = 2;
    localparam int REPORT_MODE_BIT = 1;
    localparam int SNAPSHOT_BIT = 0;
    localparam int TX_TERM_LSB = 3;
    localparam int RX_TERM_LSB = 0;
    localparam int DF_BIT = 2;
    localparam int LOS_BIT = 0;
    localparam int PSUM_BIT = 6;
    localparam int TJA_BIT = 5;
    localparam int RJA_BIT = 4;
    localparam int EXZ_BIT = 2;
    localparam int CV_BIT = 1;
    localparam int CNTOV_BIT = 0;

    // Writable bit masks and reset values.
    localparam logic [7:0] MASK_RX_CODE = 8'h01;
    localparam logic [7:0] MASK_LOSS_LEVEL = 8'h1F;
    localparam logic [7:0] MASK_LOSS_RESP = 8'h1C;
    localparam logic [7:0] MASK_MAINT2 = 8'h5F;
    localparam logic [7:0] MASK_TERM = 8'h3F;
    localparam logic [7:0] MASK_LINE = 8'h05;
    localparam logic [7:0] MASK_ERR = 8'h77;
    localparam logic [7:0] RST_LOSS_LEVEL = 8'h15;
    localparam logic [7:0] RST_TERM = 8'h07;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [1:0] CNT_EN_CODE = 2'h1;

    // Loss of signal declare and clear counts, in bit intervals.
    localparam logic [10:0] DECLARE_T1231 = 11'h0AF;
    localparam logic [10:0] DECLARE_I431 = 11'h608;
    localparam logic [7:0] CLEAR_MIN_MARKS = 8'h10;
    localparam logic [6:0] CLEAR_ZERO_RUN = 7'h64;
    localparam logic [6:0] CLEAR_WINDOW_LAST = 7'h7F;

    // Excessive zero limits; an error is one zero beyond the limit.
    localparam logic [6:0] EXZ_ANSI_AMI = 7'h0F;
    localparam logic [6:0] EXZ_FCC_AMI = 7'h50;
    localparam logic [6:0] EXZ_B8ZS = 7'h07;

    // Clear level sits 4 dB above declare level, 2 dB per threshold code.
    localparam int HYST_DB = 4;
    localparam int DB_PER_CODE = 2;
    localparam logic [4:0] HYST_CODES = 5'(HYST_DB / DB_PER_CODE);

    // One second report tick.
    localparam int CLK_PERIOD_NS = 8;
    localparam int SECOND_NS = 1000000000;
    localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;

endpackage

// file: lae_loss_detect.sv
// Loss of signal declare and clear detector.
// Assumes synchronised level and mark inputs, one bit interval per clock.
`timescale 1ns/1ps
module lae_loss_detect (
    input wire logic clk,
    input wire logic rstn,
    input wire logic bit_mark,
    input wire logic level_low,
    input wire logic level_ok,
    input wire logic criterion,
    output logic loss
);
    import lae_pkg::*;

    logic [10:0] low_run;
    logic [10:0] declare_len;
    logic [6:0] win_pos;
    logic [7:0] marks;
    logic [6:0] zero_run;
    logic bad;
    logic [7:0] next_marks;
    logic [6:0] next_zero_run;
    logic next_bad;

    // Window terms including the bit of this cycle.
    always_comb begin
        declare_len = criterion ? DECLARE_I431 : DECLARE_T1231;
        next_marks = marks + 8'(bit_mark);
        next_zero_run = bit_mark ? 7'h00 : zero_run + 7'h01;
        next_bad = bad | ~level_ok | (next_zero_run >= CLEAR_ZERO_RUN);
    end

    // Counts consecutive low-level bit intervals, saturating.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            low_run <= 11'h000;
        end else if (!level_low) begin
            low_run <= 11'h000;
        end else if (low_run != 11'h7FF) begin
            low_run <= low_run + 11'h001;
        end
    end

    // Clear window of 128 bit periods, restarted while no loss stands.
    always_ff @(posedge clk) begin
        if (!rstn || !loss || win_pos == CLEAR_WINDOW_LAST) begin
            win_pos <= 7'h00;
            marks <= 8'h00;
            zero_run <= 7'h00;
            bad <= 1'b0;
        end else begin
            win_pos <= win_pos + 7'h01;
            marks <= next_marks;
            zero_run <= next_zero_run;
            bad <= next_bad;
        end
    end

    // Declares after the full low run, clears on a clean window.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            loss <= 1'b0;
        end else if (!loss) begin
            if (level_low && low_run == declare_len - 11'h001) begin
                loss <= 1'b1;
            end
        end else if (win_pos == CLEAR_WINDOW_LAST && !next_bad &&
                     next_marks >= CLEAR_MIN_MARKS) begin
            loss <= 1'b0;
        end
    end
endmodule

// file: lae_front_end_model.sv
// Behavioural model of the analog line front end on the receive side.
// Assumes one bit interval per clock and a line that is either live or silent.
`timescale 1ns/1ps
module lae_front_end_model (
    input wire logic clk,
    input wire logic silent,
    input wire logic [7:0] zeros,
    input wire logic go,
    output logic mark,
    output logic low,
    output logic ok
);
    int left = 0;

    // A go pulse starts a run of the given number of zero bits.
    always @(posedge clk) begin
        if (go) begin
            left <= zeros;
        end else if (left > 0) begin
            left <= left - 1;
        end
    end

    // A silent line carries no pulses and sits below the declare level.
    assign mark = !silent && left == 0;
    assign low = silent;
    assign ok = !silent;
endmodule

// file: lae_line_maint_properties.sv
// Port-level checker for the line maintenance block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module lae_line_maint_props (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic tx_data,
    input wire logic tx_data_out,
    input wire logic tx_bpv_insert,
    input wire logic [4:0] los_declare_code,
    input wire logic [4:0] los_clear_code,
    input wire logic [3:0] tx_match,
    input wire logic [3:0] rx_match,
    input wire logic rx_term_bypass
);
    import lae_pkg::*;
    logic [7:0] wd1;
    logic [7:0] wd2;
    logic inj_req;
    logic term_wr;
    logic lvl_wr;

    // Write data two cycles back, for registered decode outputs.
    always_ff @(posedge clk) begin
        wd1 <= wdata;
        wd2 <= wd1;
    end

    // Writes that lead to an output change.
    assign inj_req = wr && addr == ADDR_MAINT2 && wdata[INJECT_BIT];
    assign term_wr = wr && addr == ADDR_TERM;
    assign lvl_wr = wr && addr == ADDR_LOSS_LEVEL;

    function automatic logic [3:0] dec(input logic [2:0] c);
        return c[2] ? 4'h0 : 4'(4'h1 << c[1:0]);
    endfunction

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_bpv_single: assert property (
        tx_bpv_insert |=> !tx_bpv_insert)
        else $error("violation insert pulse too long");
    a_bpv_cause: assert property (
        tx_bpv_insert |-> $past(inj_req, 2))
        else $error("violation insert without inject write");
    a_tx_term: assert property (
        term_wr ##1 !term_wr |=> tx_match == dec(wd2[5:3]))
        else $error("transmit matching decode wrong");
    a_rx_term: assert property (
        term_wr ##1 !term_wr |=>
        {rx_term_bypass, rx_match} == {wd2[2], dec(wd2[2:0])})
        else $error("receive matching decode wrong");
    a_declare_code: assert property (
        lvl_wr ##1 !lvl_wr |=> los_declare_code == wd2[4:0])
        else $error("declare level does not follow write");
    a_clear_hyst: assert property (
        los_clear_code == (los_declare_code < HYST_CODES ? 5'h00 :
        5'(los_declare_code - HYST_CODES)))
        else $error("clear level not offset from declare level");
    a_tx_ones_or: assert property (
        $past(rstn) && $past(tx_data) |-> tx_data_out)
        else $error("transmit mark lost");
    a_rdata_idle: assert property (
        !$past(rd) |-> rdata == 8'h00)
        else $error("read data outside answer cycle");
endmodule

bind lae_line_maint lae_line_maint_props u_props (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .tx_data(tx_data), .tx_data_out(tx_data_out),
    .tx_bpv_insert(tx_bpv_insert), .los_declare_code(los_declare_code),
    .los_clear_code(los_clear_code), .tx_match(tx_match),
    .rx_match(rx_match), .rx_term_bypass(rx_term_bypass)
);

// file: testbench.sv
// Self-checking bench for the line maintenance block.
// Assumes the front end model on the receive pins and a short second.
`timescale 1ns/1ps
module testbench;
    import lae_pkg::*;
    logic clk = 0, rstn = 0, wr = 0, rd = 0, tx_data = 0, rd_d = 0;
    logic silent = 0, go = 0, mark, low, ok, rx_o, tx_o, bpv, byp, int_n;
    logic [7:0] addr = 0, wdata = 0, zeros = 0, rnd, rdata, q[$];
    logic [4:0] ev = 0, dcode, ccode;
    logic [3:0] txm, rxm;
    int num_errors = 0, cmp_count = 0, cycles = 0, bpvs = 0, b0;
    logic [7:0] wa[8] = '{ADDR_RX_CODE, ADDR_LOSS_LEVEL, ADDR_LOSS_RESP,
        ADDR_MAINT2, ADDR_TERM, ADDR_LINE_IEN, ADDR_ERR_IEN, ADDR_EDGE};
    logic [7:0] wm[8] = '{MASK_RX_CODE, MASK_LOSS_LEVEL, MASK_LOSS_RESP,
        MASK_MAINT2, MASK_TERM, MASK_LINE, MASK_ERR, MASK_LINE};
    logic [7:0] wv[8] = '{RST_ZERO, RST_LOSS_LEVEL, RST_ZERO, RST_ZERO,
        RST_TERM, RST_ZERO, RST_ZERO, RST_ZERO};
    logic [7:0] ro[6] = '{ADDR_LINE_STATUS, ADDR_LINE_FLAGS, ADDR_ERR_FLAGS,
        ADDR_CNT_HIGH, ADDR_CNT_LOW, 8'h00};
    logic [7:0] zc[6] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h01};
    logic [7:0] zd[6] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h14, 8'h14};
    logic [7:0] zl[6] = '{8'h07, 8'h08, 8'h0F, 8'h10, 8'h50, 8'h51};
    logic [7:0] zf[6] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h00, 8'h04};
    logic [7:0] eb[5] = '{8'h40, 8'h20, 8'h10, 8'h02, 8'h04};

    lae_line_maint #(.SECOND_CYCLES(50)) dut (.clk(clk), .rstn(rstn),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .rx_mark_pin(mark), .rx_level_low_pin(low), .rx_level_ok_pin(ok),
        .driver_fail_pin(ev[4]), .pulse_sum_overflow(ev[0]),
        .tx_jitter_slip(ev[1]), .rx_jitter_slip(ev[2]),
        .bipolar_violation(ev[3]), .tx_data(tx_data), .rx_data_out(rx_o),
        .tx_data_out(tx_o), .tx_bpv_insert(bpv), .los_declare_code(dcode),
        .los_clear_code(ccode), .tx_match(txm), .rx_match(rxm),
        .rx_term_bypass(byp), .int_n(int_n));
    lae_front_end_model fe (.clk(clk), .silent(silent), .zeros(zeros),
        .go(go), .mark(mark), .low(low), .ok(ok));

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got,
                exp);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d, errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask

    // The expected read value is queued for the read monitor.
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1;
        q.push_back(e);
        @(posedge clk);
        rd <= 0;
    endtask

    task automatic zrun(input logic [7:0] n);
        @(posedge clk);
        zeros <= n;
        go <= 1;
        @(posedge clk);
        go <= 0;
        cyc(120);
    endtask

    // Read data is compared in the cycle after each read strobe.
    always @(posedge clk) begin
        if (rd_d) begin
            check(rdata, q.pop_front());
        end
        rd_d <= rd;
        tx_data <= 1'($urandom);
        bpvs <= bpvs + int'(bpv === 1'b1);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            test_done();
        end
    end

    initial begin
        rnd = 8'($urandom(32'h2D3F));
        repeat (10) @(posedge clk);
        rstn <= 1;
        cyc(2);
        foreach (wa[i]) reg_rd(wa[i], wv[i]);
        foreach (wa[i]) begin
            rnd = 8'($urandom);
            reg_wr(wa[i], rnd);
            reg_rd(wa[i], rnd & wm[i]);
        end
        foreach (ro[i]) begin
            reg_wr(ro[i], 8'hFF);
            reg_rd(ro[i], RST_ZERO);
        end
        foreach (wa[i]) reg_wr(wa[i], RST_ZERO);
        for (int c = 0; c < 8; c++) begin
            reg_wr(ADDR_TERM, 8'(c * 9));
            cyc(3);
            check(8'(txm), 8'(c[2] ? 0 : 1 << c[1:0]));
            check(8'(rxm), 8'(c[2] ? 0 : 1 << c[1:0]));
            check(8'(byp), 8'(c[2]));
        end
        foreach (zl[i]) begin
            reg_wr(ADDR_LOSS_LEVEL, zl[i] & MASK_LOSS_LEVEL);
            cyc(3);
            check(8'(dcode), zl[i] & MASK_LOSS_LEVEL);
            check(8'(ccode), zl[i] < 2 ? 0 : (zl[i] & 8'h1F) - 2);
        end
        reg_wr(ADDR_LOSS_LEVEL, 8'h01);
        cyc(3);
        check(8'(ccode), 8'h00);
        b0 = bpvs;
        reg_wr(ADDR_MAINT2, 8'h40);
        reg_wr(ADDR_MAINT2, 8'h40);
        cyc(4);
        check(8'(bpvs - b0), 8'h01);
        reg_wr(ADDR_MAINT2, 8'h00);
        reg_wr(ADDR_MAINT2, 8'h40);
        cyc(4);
        check(8'(bpvs - b0), 8'h02);
        reg_wr(ADDR_MAINT2, 8'h00);
        reg_wr(ADDR_LOSS_RESP, 8'h0C);
        reg_wr(ADDR_LINE_IEN, 8'h01);
        @(posedge clk) silent <= 1;
        cyc(170);
        check(8'(rx_o), 8'h00);
        cyc(12);
        check(8'(rx_o), 8'h01);
        check(8'(tx_o), 8'h01);
        check(8'(int_n), 8'h00);
        reg_rd(ADDR_LINE_STATUS, 8'h01);
        reg_wr(ADDR_LINE_FLAGS, 8'h01);
        reg_rd(ADDR_LINE_FLAGS, 8'h00);
        cyc(2);
        check(8'(int_n), 8'h01);
        @(posedge clk) silent <= 0;
        cyc(300);
        reg_rd(ADDR_LINE_STATUS, 8'h00);
        reg_rd(ADDR_LINE_FLAGS, 8'h00);
        reg_wr(ADDR_LOSS_RESP, 8'h10);
        reg_wr(ADDR_EDGE, 8'h01);
        @(posedge clk) silent <= 1;
        cyc(1530);
        reg_rd(ADDR_LINE_STATUS, 8'h00);
        cyc(30);
        check(8'(rx_o), 8'h00);
        reg_rd(ADDR_LINE_STATUS, 8'h01);
        reg_wr(ADDR_LINE_FLAGS, 8'h01);
        @(posedge clk) silent <= 0;
        cyc(300);
        reg_rd(ADDR_LINE_FLAGS, 8'h01);
        reg_wr(ADDR_LINE_IEN, 8'h00);
        foreach (zl[i]) begin
            reg_wr(ADDR_RX_CODE, zc[i]);
            reg_wr(ADDR_MAINT2, zd[i]);
            reg_wr(ADDR_ERR_FLAGS, MASK_ERR);
            zrun(zl[i]);
            reg_rd(ADDR_ERR_FLAGS, zf[i]);
        end
        reg_wr(ADDR_MAINT2, 8'h15);
        cyc(3);
        reg_rd(ADDR_CNT_LOW, 8'h03);
        reg_rd(ADDR_CNT_HIGH, 8'h00);
        reg_wr(ADDR_MAINT2, 8'h08);
        zrun(8'h14);
        reg_wr(ADDR_MAINT2, 8'h09);
        cyc(3);
        reg_rd(ADDR_CNT_LOW, 8'h03);
        reg_wr(ADDR_MAINT2, 8'h06);
        zrun(8'h14);
        cyc(60);
        reg_rd(ADDR_CNT_LOW, 8'h04);
        foreach (eb[i]) begin
            reg_wr(i == 4 ? ADDR_LINE_FLAGS : ADDR_ERR_FLAGS, 8'hFF);
            @(posedge clk) ev[i] <= 1;
            @(posedge clk) ev[i] <= 0;
            cyc(5);
            check(8'(int_n), 8'h01);
            reg_rd(i == 4 ? ADDR_LINE_FLAGS : ADDR_ERR_FLAGS, eb[i]);
            reg_wr(i == 4 ? ADDR_LINE_IEN : ADDR_ERR_IEN, eb[i]);
            cyc(3);
            check(8'(int_n), 8'h00);
            reg_wr(i == 4 ? ADDR_LINE_FLAGS : ADDR_ERR_FLAGS, eb[i]);
            cyc(3);
            check(8'(int_n), 8'h01);
            reg_wr(i == 4 ? ADDR_LINE_IEN : ADDR_ERR_IEN, 8'h00);
        end
        cyc(3);
        test_done();
    end
endmodule
